// ==== include/scs_regs.svh ====
// Operation
// R1 - Fast RC postscaler, factor from bits 10:8
// R2 - Power-on source from configuration fields
// R3 - Erased device starts fast RC divide-by-N
// R4 - Eight-way initial source code decode
// R5 - Primary submode decode, ignored otherwise
// R6 - Instruction clock is oscillator divided by two
// R7 - Software keeps instruction clock at most 40 MHz
// R8 - Prescale N1 2..33 from bits 4:0
// R9 - Software keeps VCO input 0.8-8 MHz
// R10 - Feedback M from bits 8:0
// R11 - Software keeps VCO output 100-200 MHz
// R12 - Postscale N2 2/4/8 from bits 7:6
// R13 - Software keeps PLL output 12.5-80 MHz
// R14 - PLL output is input times M/(N1*N2)
// R15 - Only primary and fast RC feed PLL
// R16 - Current source read-only at bits 14:12
// R17 - Requested source at 10:8, loaded at POR
// R18 - Slow RC clocks watchdog and failsafe monitor
// R19 - M equals feedback field plus two
// R20 - Postscale codes 00/01/11, 10 reserved
// R21 - Switch request starts switch, clears when done
// R22 - Failure sets clock fail flag, software clears
`ifndef SCS_REGS_SVH
`define SCS_REGS_SVH

// ----------------------------------------
// Register offsets (word index)
// ----------------------------------------
`define SCS_OSC_CONTROL_OFS 2'h0
`define SCS_CLOCK_DIVISOR_OFS 2'h1
`define SCS_PLL_FEEDBACK_OFS 2'h2

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SCS_CUR_SRC_LSB 12
`define SCS_REQ_SRC_LSB 8
`define SCS_SRC_LOCK_BIT 7
`define SCS_PIN_LOCK_BIT 6
`define SCS_PLL_LOCK_BIT 5
`define SCS_FAIL_BIT 3
`define SCS_LPOSC_BIT 1
`define SCS_SWITCH_BIT 0
`define SCS_FRC_DIV_LSB 8
`define SCS_POST_LSB 6
`define SCS_PRE_LSB 0

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define SCS_FRC_DIV_RST 3'h0
`define SCS_POST_RST 2'h1
`define SCS_PRE_RST 5'h00
`define SCS_FEEDBACK_RST 9'h030
`define SCS_ERASED_SRC 3'h7
`define SCS_SETTLE_CYCLES 4'h8
`define SCS_DIV16 9'h010

`endif

// ==== include/scs_pkg.sv ====
package scs_pkg;
    // Source encoding shared by current and requested fields
    typedef enum logic [2:0] {
        SRC_FRC = 3'h0,
        SRC_FRC_PLL = 3'h1,
        SRC_PRI = 3'h2,
        SRC_PRI_PLL = 3'h3,
        SRC_SEC = 3'h4,
        SRC_SLOW_RC = 3'h5,
        SRC_FRC_DIV16 = 3'h6,
        SRC_FRC_DIVN = 3'h7
    } scs_source_t;

    // Twelve resolved clock modes
    typedef enum logic [3:0] {
        MODE_FAST_RC, MODE_FAST_RC_PLL, MODE_HS, MODE_XT, MODE_EXT,
        MODE_HS_PLL, MODE_XT_PLL, MODE_EXT_PLL, MODE_SECONDARY,
        MODE_SLOW_RC, MODE_FRC_DIV16, MODE_FRC_DIVN
    } scs_mode_t;

    typedef enum {SW_IDLE, SW_SETTLE} scs_sw_state_t;
endpackage

// ==== verilog/scs_clock_select.sv ====
`timescale 1ns/1ps
`include "scs_regs.svh"

module scs_clock_select (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [2:0] initial_source_cfg,
    input wire logic [1:0] primary_submode_cfg,
    input wire logic clk_switch_en_cfg,
    input wire logic [1:0] addr,
    input wire logic [15:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [15:0] rd_data,
    input wire logic fast_rc_tick,
    input wire logic primary_tick,
    input wire logic secondary_tick,
    input wire logic slow_rc_tick,
    input wire logic pll_tick,
    input wire logic pll_locked,
    input wire logic clock_fail_event,
    output logic osc_tick,
    output logic instr_tick,
    output logic wdt_ref_tick,
    output logic failsafe_monitor_ref_tick,
    output logic pll_enable,
    output logic pll_src_primary,
    output logic [5:0] pll_prescale_div,
    output logic [9:0] pll_feedback_mult,
    output logic [3:0] pll_postscale_div,
    output logic [8:0] fast_rc_postscale_div,
    output scs_pkg::scs_mode_t osc_mode,
    output logic low_power_osc_enable,
    output logic pinselect_lock
);

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [2:0] cur_q, cur_d;
    logic [2:0] req_q, req_d;
    logic sw_q, sw_d;
    logic cf_q, cf_d;
    logic src_lock_q, src_lock_d;
    logic pin_lock_q, pin_lock_d;
    logic lposc_q, lposc_d;
    logic [2:0] frc_div_q, frc_div_d;
    logic [1:0] post_q, post_d;
    logic [4:0] pre_q, pre_d;
    logic [8:0] fb_q, fb_d;
    logic [3:0] cnt_q, cnt_d;
    logic [8:0] pscnt_q, pscnt_d;
    logic ps_tick_q, ps_tick_d;
    logic ph_q, ph_d;
    logic instr_q, instr_d;
    scs_pkg::scs_sw_state_t st_q, st_d;

    // ----------------------------------------
    // Register decode
    // ----------------------------------------
    wire wr_osc = wr_en && addr == `SCS_OSC_CONTROL_OFS;
    wire wr_div = wr_en && addr == `SCS_CLOCK_DIVISOR_OFS;
    wire wr_fb = wr_en && addr == `SCS_PLL_FEEDBACK_OFS;
    wire [15:0] osc_word = {1'b0, cur_q, 1'b0, req_q, src_lock_q, pin_lock_q,
        pll_locked, 1'b0, cf_q, 1'b0, lposc_q, sw_q}; // [R16]
    wire [15:0] div_word = {5'h00, frc_div_q, post_q, 1'b0, pre_q};
    wire [15:0] fb_word = {7'h00, fb_q};
    wire [15:0] rd_mux = (addr == `SCS_OSC_CONTROL_OFS) ? osc_word :
                         (addr == `SCS_CLOCK_DIVISOR_OFS) ? div_word :
                         (addr == `SCS_PLL_FEEDBACK_OFS) ? fb_word : 16'h0000;

    // Read data registered, stands only in the cycle after the strobe
    always_ff @(posedge mclk) begin
        if (reset) begin
            rd_data <= 16'h0000;
        end else begin
            rd_data <= rd_en ? rd_mux : 16'h0000;
        end
    end

    // ----------------------------------------
    // Switch sequencer
    // ----------------------------------------
    // PLL to PLL hops are refused; software must pass through a non-PLL source
    wire pll_hop = (cur_q == scs_pkg::SRC_FRC_PLL && req_q == scs_pkg::SRC_PRI_PLL) ||
                   (cur_q == scs_pkg::SRC_PRI_PLL && req_q == scs_pkg::SRC_FRC_PLL);
    wire sw_abort = sw_q && (req_q == cur_q || pll_hop || src_lock_q);
    wire sw_start = sw_q && !sw_abort;
    wire sw_done = st_q == scs_pkg::SW_SETTLE && cnt_q == `SCS_SETTLE_CYCLES - 4'h1;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        cur_d = cur_q;
        unique case (st_q)
            scs_pkg::SW_IDLE: begin
                cnt_d = 4'h0;
                if (sw_start && clk_switch_en_cfg) begin
                    st_d = scs_pkg::SW_SETTLE; // [R21]
                end
            end
            scs_pkg::SW_SETTLE: begin
                cnt_d = cnt_q + 4'h1;
                if (sw_done) begin
                    st_d = scs_pkg::SW_IDLE;
                    cur_d = req_q; // [R21]
                end
            end
        endcase
        // With switching enabled, failure falls back to fast RC, overriding any switch in flight
        if (clock_fail_event && clk_switch_en_cfg) begin
            st_d = scs_pkg::SW_IDLE;
            cur_d = scs_pkg::SRC_FRC;
        end
    end

    // ----------------------------------------
    // Software field next values
    // ----------------------------------------
    always_comb begin
        req_d = wr_osc ? wr_data[`SCS_REQ_SRC_LSB +: 3] : req_q; // [R17]
        src_lock_d = wr_osc ? wr_data[`SCS_SRC_LOCK_BIT] : src_lock_q;
        pin_lock_d = wr_osc ? wr_data[`SCS_PIN_LOCK_BIT] : pin_lock_q;
        lposc_d = wr_osc ? wr_data[`SCS_LPOSC_BIT] : lposc_q;
        // Held low while switching is disabled; cleared on abort or finish
        if (!clk_switch_en_cfg) begin
            sw_d = 1'b0;
        end else if (wr_osc) begin
            sw_d = wr_data[`SCS_SWITCH_BIT];
        end else if (sw_done || (st_q == scs_pkg::SW_IDLE && sw_abort)) begin
            sw_d = 1'b0; // [R21]
        end else begin
            sw_d = sw_q;
        end
        // Set wins over a clearing write in the same cycle
        cf_d = clock_fail_event ||
               (cf_q && !(wr_osc && !wr_data[`SCS_FAIL_BIT])); // [R22]
        frc_div_d = wr_div ? wr_data[`SCS_FRC_DIV_LSB +: 3] : frc_div_q; // [R1]
        post_d = wr_div ? wr_data[`SCS_POST_LSB +: 2] : post_q; // [R12]
        pre_d = wr_div ? wr_data[`SCS_PRE_LSB +: 5] : pre_q; // [R8]
        fb_d = wr_fb ? wr_data[8:0] : fb_q; // [R10]
    end

    // Power-on values; configuration fields are caught on the reset cycle
    always_ff @(posedge mclk) begin
        if (reset) begin
            cur_q <= initial_source_cfg; // [R2] [R3]
            req_q <= initial_source_cfg; // [R17]
            sw_q <= 1'b0;
            cf_q <= 1'b0;
            src_lock_q <= 1'b0;
            pin_lock_q <= 1'b0;
            lposc_q <= 1'b0;
            frc_div_q <= `SCS_FRC_DIV_RST;
            post_q <= `SCS_POST_RST;
            pre_q <= `SCS_PRE_RST;
            fb_q <= `SCS_FEEDBACK_RST;
            st_q <= scs_pkg::SW_IDLE;
            cnt_q <= 4'h0;
        end else begin
            cur_q <= cur_d;
            req_q <= req_d;
            sw_q <= sw_d;
            cf_q <= cf_d;
            src_lock_q <= src_lock_d;
            pin_lock_q <= pin_lock_d;
            lposc_q <= lposc_d;
            frc_div_q <= frc_div_d;
            post_q <= post_d;
            pre_q <= pre_d;
            fb_q <= fb_d;
            st_q <= st_d;
            cnt_q <= cnt_d;
        end
    end

    // ----------------------------------------
    // Mode and PLL factor decode
    // ----------------------------------------
    // Submode only matters for the two primary codes
    always_comb begin
        unique case (cur_q)
            scs_pkg::SRC_FRC: osc_mode = scs_pkg::MODE_FAST_RC; // [R4]
            scs_pkg::SRC_FRC_PLL: osc_mode = scs_pkg::MODE_FAST_RC_PLL;
            scs_pkg::SRC_PRI: osc_mode = primary_submode_cfg == 2'h2 ? scs_pkg::MODE_HS :
                primary_submode_cfg == 2'h1 ? scs_pkg::MODE_XT : scs_pkg::MODE_EXT; // [R5]
            scs_pkg::SRC_PRI_PLL: osc_mode = primary_submode_cfg == 2'h2 ?
                scs_pkg::MODE_HS_PLL : primary_submode_cfg == 2'h1 ?
                scs_pkg::MODE_XT_PLL : scs_pkg::MODE_EXT_PLL; // [R5]
            scs_pkg::SRC_SEC: osc_mode = scs_pkg::MODE_SECONDARY;
            scs_pkg::SRC_SLOW_RC: osc_mode = scs_pkg::MODE_SLOW_RC;
            scs_pkg::SRC_FRC_DIV16: osc_mode = scs_pkg::MODE_FRC_DIV16;
            default: osc_mode = scs_pkg::MODE_FRC_DIVN;
        endcase
    end

    // Factors go to the analog loop, which makes Fin*M/(N1*N2)
    assign pll_prescale_div = {1'b0, pre_q} + 6'h02; // [R8] [R14]
    assign pll_feedback_mult = {1'b0, fb_q} + 10'h002; // [R19] [R14]
    // Reserved postscale code falls back to the reset divide of four
    assign pll_postscale_div = post_q == 2'h0 ? 4'h2 :
                               post_q == 2'h3 ? 4'h8 : 4'h4; // [R20]
    assign fast_rc_postscale_div = frc_div_q == 3'h7 ? 9'h100 :
                                   9'(9'h001 << frc_div_q); // [R1]
    assign pll_enable = cur_q == scs_pkg::SRC_FRC_PLL || cur_q == scs_pkg::SRC_PRI_PLL;
    assign pll_src_primary = cur_q == scs_pkg::SRC_PRI_PLL; // [R15]
    assign low_power_osc_enable = lposc_q;
    assign pinselect_lock = pin_lock_q;
    assign wdt_ref_tick = slow_rc_tick; // [R18]
    assign failsafe_monitor_ref_tick = slow_rc_tick; // [R18]

    // ----------------------------------------
    // Fast RC postscaler and clock mux
    // ----------------------------------------
    wire [8:0] ps_div = cur_q == scs_pkg::SRC_FRC_DIV16 ? `SCS_DIV16 : fast_rc_postscale_div;
    wire ps_wrap = pscnt_q >= ps_div - 9'h001;
    assign pscnt_d = fast_rc_tick ? (ps_wrap ? 9'h000 : pscnt_q + 9'h001) : pscnt_q;
    assign ps_tick_d = fast_rc_tick && ps_wrap; // [R1]

    always_comb begin
        unique case (cur_q)
            scs_pkg::SRC_FRC: osc_tick = fast_rc_tick;
            scs_pkg::SRC_FRC_PLL, scs_pkg::SRC_PRI_PLL: osc_tick = pll_tick; // [R15]
            scs_pkg::SRC_PRI: osc_tick = primary_tick;
            scs_pkg::SRC_SEC: osc_tick = secondary_tick;
            scs_pkg::SRC_SLOW_RC: osc_tick = slow_rc_tick;
            default: osc_tick = ps_tick_q;
        endcase
    end

    // Every second oscillator tick becomes one instruction tick
    assign ph_d = osc_tick ? !ph_q : ph_q;
    assign instr_d = osc_tick && ph_q; // [R6]
    assign instr_tick = instr_q;

    always_ff @(posedge mclk) begin
        if (reset) begin
            pscnt_q <= 9'h000;
            ps_tick_q <= 1'b0;
            ph_q <= 1'b0;
            instr_q <= 1'b0;
        end else begin
            pscnt_q <= pscnt_d;
            ps_tick_q <= ps_tick_d;
            ph_q <= ph_d;
            instr_q <= instr_d;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    // Oscillator ticks since the last instruction tick; saturates so a stall shows
    logic [1:0] osc_seen_q;
    always_ff @(posedge mclk) begin
        if (reset) begin
            osc_seen_q <= 2'h0;
        end else if (instr_tick) begin
            osc_seen_q <= {1'b0, osc_tick};
        end else if (osc_tick && osc_seen_q != 2'h3) begin
            osc_seen_q <= osc_seen_q + 2'h1;
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (reset);

    por_source_a: assert property ($fell(reset) |-> // [R2]
        cur_q == $past(initial_source_cfg) && req_q == $past(initial_source_cfg))
        else $error("power-on source not taken from configuration");
    redundant_abort_a: assert property ( // [R21]
        st_q == scs_pkg::SW_IDLE && sw_q && req_q == cur_q && !wr_en |=> !sw_q)
        else $error("redundant switch not cleared");
    switch_done_a: assert property (sw_done && !clock_fail_event |=> // [R21]
        cur_q == $past(req_q) && !sw_q && st_q == scs_pkg::SW_IDLE)
        else $error("switch completion wrong");
    fail_flag_a: assert property (clock_fail_event |=> cf_q) // [R22]
        else $error("clock fail flag not set");
    cur_read_a: assert property (rd_en && addr == `SCS_OSC_CONTROL_OFS |=> // [R16]
        rd_data[14:12] == $past(cur_q) && rd_data[10:8] == $past(req_q))
        else $error("source fields read wrong");
    instr_half_a: assert property (instr_tick |-> !$past(instr_tick)) // [R6]
        else $error("instruction tick faster than half rate");
    feedback_dec_a: assert property (fb_q == 9'h1FF |-> pll_feedback_mult == 10'h201) // [R19]
        else $error("feedback factor wrong");
    post_dec_a: assert property (post_q == 2'h3 |-> pll_postscale_div == 4'h8) // [R20]
        else $error("postscale of eight wrong");
    pre_range_a: assert property ( // [R8]
        pll_prescale_div >= 6'h02 && pll_prescale_div <= 6'h21)
        else $error("prescale out of range");
    pll_src_a: assert property (pll_src_primary |-> pll_enable) // [R15]
        else $error("pll fed outside pll mode");
    instr_pair_a: assert property (instr_tick |-> osc_seen_q == 2'h2) // [R6]
        else $error("instruction tick not after two oscillator ticks");
    // Field writes land on the following edge
    req_write_a: assert property (wr_osc |=> // [R17]
        req_q == $past(wr_data[`SCS_REQ_SRC_LSB +: 3]))
        else $error("requested source write lost");
    cur_ro_a: assert property ( // [R16]
        wr_osc && st_q == scs_pkg::SW_IDLE && !clock_fail_event |=> $stable(cur_q))
        else $error("current source changed by a write");
    div_write_a: assert property (wr_div |=> // [R1] [R8] [R12]
        frc_div_q == $past(wr_data[`SCS_FRC_DIV_LSB +: 3]) &&
        post_q == $past(wr_data[`SCS_POST_LSB +: 2]) &&
        pre_q == $past(wr_data[`SCS_PRE_LSB +: 5]))
        else $error("divisor write lost");
    fb_write_a: assert property (wr_fb |=> fb_q == $past(wr_data[8:0])) // [R10]
        else $error("feedback write lost");
    fail_clear_a: assert property ( // [R22]
        cf_q && wr_osc && !wr_data[`SCS_FAIL_BIT] && !clock_fail_event |=> !cf_q)
        else $error("clock fail flag not cleared");
    sw_off_a: assert property (!clk_switch_en_cfg |=> !sw_q) // [R21]
        else $error("switch request held while switching disabled");
    // Source routing per current code
    sec_mode_a: assert property (cur_q == scs_pkg::SRC_SEC |-> // [R4] [R15]
        osc_mode == scs_pkg::MODE_SECONDARY && osc_tick == secondary_tick && !pll_enable)
        else $error("secondary source routed wrong");
    slow_mode_a: assert property (cur_q == scs_pkg::SRC_SLOW_RC |-> // [R15]
        osc_tick == slow_rc_tick && !pll_enable)
        else $error("slow rc source routed wrong");
    pll_mode_a: assert property (cur_q == scs_pkg::SRC_FRC_PLL |-> // [R15]
        pll_enable && !pll_src_primary && osc_tick == pll_tick)
        else $error("fast rc pll routed wrong");
    hs_mode_a: assert property ( // [R5]
        cur_q == scs_pkg::SRC_PRI && primary_submode_cfg == 2'h2 |->
        osc_mode == scs_pkg::MODE_HS && osc_tick == primary_tick)
        else $error("high speed crystal mode wrong");
    ext_pll_a: assert property ( // [R5]
        cur_q == scs_pkg::SRC_PRI_PLL && primary_submode_cfg == 2'h0 |->
        osc_mode == scs_pkg::MODE_EXT_PLL)
        else $error("external clock pll mode wrong");
    div16_a: assert property (cur_q == scs_pkg::SRC_FRC_DIV16 |-> // [R4]
        osc_mode == scs_pkg::MODE_FRC_DIV16 && ps_div == `SCS_DIV16)
        else $error("fixed divide by sixteen wrong");
    // Factor end points and the feedback reset value
    frc_top_a: assert property (frc_div_q == 3'h7 |-> fast_rc_postscale_div == 9'h100) // [R1]
        else $error("fast rc divide by 256 wrong");
    fb_zero_a: assert property (fb_q == 9'h000 |-> pll_feedback_mult == 10'h002) // [R19]
        else $error("feedback factor of two wrong");
    fb_reset_a: assert property ( // [R19]
        fb_q == `SCS_FEEDBACK_RST |-> pll_feedback_mult == 10'h032)
        else $error("feedback factor of fifty wrong");
    pre_end_a: assert property (pre_q == 5'h1F |-> pll_prescale_div == 6'h21) // [R8]
        else $error("prescale of 33 wrong");
    post_two_a: assert property (post_q == 2'h0 |-> pll_postscale_div == 4'h2) // [R20]
        else $error("postscale of two wrong");

endmodule

// ==== verif/scs_osc_model.sv ====
`timescale 1ns/1ps

// ----------------------------------------
// Oscillator sources beyond the pins
// ----------------------------------------
module scs_osc_model (
    input wire logic mclk,
    input wire logic reset,
    output logic fast_rc_tick,
    output logic primary_tick,
    output logic secondary_tick,
    output logic slow_rc_tick,
    output logic pll_tick,
    output logic pll_locked
);
    logic [7:0] cnt_q;
    logic lock_q;

    // Lock comes late after start-up, so an early status read must see it low
    always_ff @(posedge mclk) begin
        if (reset) begin
            cnt_q <= 8'h00;
            lock_q <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 8'h01;
            lock_q <= lock_q | (cnt_q == 8'h10);
        end
    end

    // Unrelated ratios so a wrong source select shows up in tick counts; pll runs at the fast RC rate in opposite phase
    assign fast_rc_tick = cnt_q[0];
    assign primary_tick = (cnt_q % 8'h03) == 8'h00;
    assign secondary_tick = (cnt_q % 8'h07) == 8'h00;
    assign slow_rc_tick = (cnt_q % 8'h0B) == 8'h00;
    assign pll_tick = lock_q & ~cnt_q[0]; // No output before lock
    assign pll_locked = lock_q;
endmodule

// ==== verif/tb_system_clock_select_pll_config.sv ====
`timescale 1ns/1ps

module tb_system_clock_select_pll_config;
    logic mclk = 1'b0, reset = 1'b1, clk_switch_en_cfg = 1'b1;
    logic [2:0] initial_source_cfg = 3'h7;
    logic [1:0] primary_submode_cfg = 2'h2, addr = 2'h0;
    logic [15:0] wr_data = 16'h0000, rd_data, d;
    logic wr_en = 1'b0, rd_en = 1'b0, clock_fail_event = 1'b0, lk;
    logic fast_rc_tick, primary_tick, secondary_tick, slow_rc_tick, pll_tick, pll_locked;
    logic osc_tick, instr_tick, wdt_ref_tick, failsafe_monitor_ref_tick, pll_enable, pll_src_primary;
    logic [5:0] pll_prescale_div;
    logic [9:0] pll_feedback_mult;
    logic [3:0] pll_postscale_div;
    logic [8:0] fast_rc_postscale_div, fb;
    scs_pkg::scs_mode_t osc_mode;
    logic low_power_osc_enable, pinselect_lock;
    int fails = 0, n_compared = 0, n_osc, n_ins, bad;

    always #25 mclk = ~mclk;

    scs_clock_select scs_clock_select_inst (.mclk(mclk), .reset(reset),
        .initial_source_cfg(initial_source_cfg), .primary_submode_cfg(primary_submode_cfg),
        .clk_switch_en_cfg(clk_switch_en_cfg), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .fast_rc_tick(fast_rc_tick),
        .primary_tick(primary_tick), .secondary_tick(secondary_tick),
        .slow_rc_tick(slow_rc_tick), .pll_tick(pll_tick), .pll_locked(pll_locked),
        .clock_fail_event(clock_fail_event), .osc_tick(osc_tick), .instr_tick(instr_tick),
        .wdt_ref_tick(wdt_ref_tick), .failsafe_monitor_ref_tick(failsafe_monitor_ref_tick), .pll_enable(pll_enable),
        .pll_src_primary(pll_src_primary), .pll_prescale_div(pll_prescale_div),
        .pll_feedback_mult(pll_feedback_mult), .pll_postscale_div(pll_postscale_div),
        .fast_rc_postscale_div(fast_rc_postscale_div), .osc_mode(osc_mode),
        .low_power_osc_enable(low_power_osc_enable), .pinselect_lock(pinselect_lock));

    scs_osc_model scs_osc_model_inst (.mclk(mclk), .reset(reset),
        .fast_rc_tick(fast_rc_tick), .primary_tick(primary_tick),
        .secondary_tick(secondary_tick), .slow_rc_tick(slow_rc_tick),
        .pll_tick(pll_tick), .pll_locked(pll_locked));

    // ----------------------------------------
    // Bus tasks and compares
    // ----------------------------------------
    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [15:0] v);
        @(posedge mclk);
        addr <= a;
        wr_data <= v;
        wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask

    // Lock level is taken just before the edge that samples it
    task automatic rd(input logic [1:0] a);
        @(posedge mclk);
        addr <= a;
        rd_en <= 1'b1;
        @(negedge mclk);
        lk = pll_locked;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1 d = rd_data;
    endtask

    // Status word: current, requested, low byte with lock folded in
    task automatic chk_osc(input logic [2:0] c, input logic [2:0] r, input logic [7:0] lo);
        rd(2'h0);
        chk(d, {1'b0, c, 1'b0, r, lo | {2'b00, lk, 5'h00}}, "osc_control");
    endtask

    task automatic do_reset();
        @(posedge mclk);
        reset <= 1'b1;
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
    endtask

    // A bounded wait for the settled mode; running out counts as a miss
    task automatic wait_mode(input scs_pkg::scs_mode_t m);
        for (int i = 0; i < 40 && osc_mode !== m; i++) begin
            @(posedge mclk);
            #1;
        end
        chk(16'(osc_mode), 16'(m), "mode after switch");
        if (osc_mode !== m) give_verdict();
    endtask

    function automatic scs_pkg::scs_mode_t mode_of(input logic [2:0] c, input logic [1:0] s);
        case (c)
            3'h0: return scs_pkg::MODE_FAST_RC;
            3'h1: return scs_pkg::MODE_FAST_RC_PLL;
            3'h2: return s == 2'h2 ? scs_pkg::MODE_HS : s == 2'h1 ? scs_pkg::MODE_XT
                                   : scs_pkg::MODE_EXT;
            3'h3: return s == 2'h2 ? scs_pkg::MODE_HS_PLL : s == 2'h1 ? scs_pkg::MODE_XT_PLL
                                   : scs_pkg::MODE_EXT_PLL;
            3'h4: return scs_pkg::MODE_SECONDARY;
            3'h5: return scs_pkg::MODE_SLOW_RC;
            3'h6: return scs_pkg::MODE_FRC_DIV16;
            default: return scs_pkg::MODE_FRC_DIVN;
        endcase
    endfunction

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        do_reset();
        chk_osc(3'h7, 3'h7, 8'h00);
        rd(2'h1);
        chk(d, 16'h0040, "divisor reset");
        rd(2'h2);
        chk(d, 16'h0030, "feedback reset");
        chk(16'(pll_feedback_mult), 16'h0032, "M at reset");
        rd(2'h3);
        chk(d, 16'h0000, "unmapped read");
        // Walk every postscaler code, prescale ends and feedback ends
        for (int c = 0; c < 8; c++) begin
            d = {5'h00, 3'(c), 2'(c), 1'b0, c[0] ? 5'h1F : 5'(c)};
            fb = (c == 7) ? 9'h1FF : 9'(c * 73);
            wr(2'h1, d);
            wr(2'h2, {7'h7F, fb});
            rd(2'h1);
            chk(d, {5'h00, 3'(c), 2'(c), 1'b0, c[0] ? 5'h1F : 5'(c)}, "divisor readback");
            chk(16'(fast_rc_postscale_div), (c == 7) ? 16'h0100 : 16'h0001 << c, "frc div");
            chk(16'(pll_postscale_div), (c % 4 == 3) ? 16'h0008 : (c % 4 == 0) ? 16'h0002
                : 16'h0004, "post div");
            chk(16'(pll_prescale_div), (c[0] ? 16'h001F : 16'(c)) + 16'h0002, "pre div");
            rd(2'h2);
            chk(d, {7'h00, fb}, "feedback readback");
            chk(16'(pll_feedback_mult), 16'(fb) + 16'h0002, "M value");
        end
        // Switches; the VCO and output ranges are the software's concern
        wr(2'h0, 16'h0201);
        wait_mode(scs_pkg::MODE_HS);
        chk_osc(3'h2, 3'h2, 8'h00);
        wr(2'h0, 16'h0301);
        wait_mode(scs_pkg::MODE_HS_PLL);
        chk({pll_enable, pll_src_primary}, 16'h0003, "pll from primary");
        wr(2'h0, 16'h0101);
        repeat (12) @(posedge mclk);
        chk_osc(3'h3, 3'h1, 8'h00);
        wr(2'h0, 16'h0501);
        wait_mode(scs_pkg::MODE_SLOW_RC);
        chk({pll_enable, pll_src_primary}, 16'h0000, "slow rc bypass");
        @(posedge mclk);
        clock_fail_event <= 1'b1;
        @(posedge mclk);
        clock_fail_event <= 1'b0;
        chk_osc(3'h0, 3'h5, 8'h08);
        wr(2'h0, 16'h0542);
        chk_osc(3'h0, 3'h5, 8'h42);
        chk({low_power_osc_enable, pinselect_lock}, 16'h0003, "control bits");
        // Redundant request clears itself; with switching disabled the bit stays low
        wr(2'h0, 16'h0043);
        chk_osc(3'h0, 3'h0, 8'h42);
        @(posedge mclk);
        clk_switch_en_cfg <= 1'b0;
        wr(2'h0, 16'h0443);
        repeat (12) @(posedge mclk);
        chk_osc(3'h0, 3'h4, 8'h42);
        @(posedge mclk);
        clk_switch_en_cfg <= 1'b1;
        // Every power-on code against submodes 0 to 2
        for (int c = 0; c < 8; c++) begin
            for (int s = 0; s < 3; s++) begin
                @(posedge mclk);
                initial_source_cfg <= 3'(c);
                primary_submode_cfg <= 2'(s);
                do_reset();
                #1 chk(16'(osc_mode), 16'(mode_of(3'(c), 2'(s))), "power-on mode");
                chk_osc(3'(c), 3'(c), 8'h00);
            end
        end
        // Last run is fast RC divide-by-N at its reset divide of one: count cycle ticks against instruction ticks
        n_osc = 0;
        n_ins = 0;
        bad = 0;
        repeat (200) begin
            @(posedge mclk);
            #1;
            n_osc += osc_tick;
            n_ins += instr_tick;
            if (wdt_ref_tick !== slow_rc_tick || failsafe_monitor_ref_tick !== slow_rc_tick) bad++;
        end
        chk(16'(n_osc), 16'h0064, "osc ticks follow fast rc");
        chk(16'(n_ins == n_osc / 2 || n_ins == n_osc / 2 - 1), 16'h0001, "half rate");
        chk(16'(bad), 16'h0000, "reference ticks");
        give_verdict();
    end
endmodule
